//--- hw/sfp_regs.svh
/*
  Constants of the serial flash pin front end: lane counts, page size,
  erase alignment masks and link start-up figures.
  Assumes inclusion by bare name from design files only.
*/
`ifndef SFP_REGS_SVH
`define SFP_REGS_SVH

// ----------------------------------------------------------------------
// Link framing
// ----------------------------------------------------------------------
`define SFP_BYTE_BITS    4'h8
`define SFP_STEP_SINGLE  4'h1
`define SFP_STEP_DUAL    4'h2
`define SFP_STEP_QUAD    4'h4
`define SFP_WARM_EDGES   2'h2
`define SFP_IDLE_BYTE    8'hFF
`define SFP_OE_SINGLE    4'h2
`define SFP_OE_DUAL      4'h3
`define SFP_OE_QUAD      4'hF
`define SFP_OE_NONE      4'h0

// ----------------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------------
`define SFP_PAGE_BYTES   9'h100
`define SFP_SECTOR_MASK  18'h3_F000
`define SFP_BLK32_MASK   18'h3_8000
`define SFP_BLK64_MASK   18'h3_0000
`define SFP_CHIP_BASE    18'h0_0000
`define SFP_LOCK_SET     1'h1

`endif

//--- hw/sfp_pkg.sv
/*
  Types shared by the serial flash pin front end.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sfp_pkg;

  // --------------------------------------------------------------------
  // Lane modes and erase granules
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {SFP_SINGLE, SFP_DUAL, SFP_QUAD} sfp_mode_e;
  typedef enum logic [1:0] {SFP_SECTOR, SFP_BLK32, SFP_BLK64,
                            SFP_CHIP} sfp_erase_e;

  // Control that crosses into the link clock as one group
  typedef struct packed {
    sfp_mode_e mode;
    logic      drive;
    logic      req;
  } sfp_link_ctl_s;

endpackage : sfp_pkg

//--- hw/sfp_sync.sv
/*
  Two flip-flop level synchroniser of parameterised width.
  Assumes each bit is a level or a toggle that settles between changes.
*/
`timescale 1ns/100ps
module sfp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,   // Destination clock
  input  wire logic         rst_n_in, // Async reset, active low
  input  wire logic [W-1:0] d_in,     // Foreign level
  output logic      [W-1:0] q_out     // Synchronised level
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_q;

  always_comb
  begin
    nxt_meta = d_in;
    nxt_q    = meta_ff;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta_ff <= '0;
      q_out   <= '0;
    end
    else
    begin
      meta_ff <= nxt_meta;
      q_out   <= nxt_q;
    end
  end

endmodule : sfp_sync

//--- hw/sfp_buf.sv
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock; all outputs come from flip-flops.
*/
`timescale 1ns/100ps
module sfp_buf #(
  parameter int W = 8
) (
  input  wire logic         clk_in,    // Clock
  input  wire logic         rst_n_in,  // Async reset, active low
  input  wire logic [W-1:0] in_data,   // Fill side data
  input  wire logic         in_valid,  // Fill side valid
  output logic              in_ready,  // Fill side ready
  output logic      [W-1:0] out_data,  // Drain side data
  output logic              out_valid, // Drain side valid
  input  wire logic         out_ready  // Drain side ready
);

  logic [W-1:0] mem_ff [2];
  logic [1:0]   vld_ff;
  logic [W-1:0] nxt_mem [2];
  logic [1:0]   nxt_vld;
  logic         push;
  logic         pop;

  assign in_ready  = ~vld_ff[1];
  assign out_data  = mem_ff[0];
  assign out_valid = vld_ff[0];

  always_comb
  begin
    push    = in_valid & ~vld_ff[1];
    pop     = vld_ff[0] & out_ready;
    nxt_mem = mem_ff;
    nxt_vld = vld_ff;
    if (pop)
    begin
      nxt_mem[0] = mem_ff[1];
      nxt_vld    = {1'b0, vld_ff[1]};
    end
    if (push)
    begin
      nxt_mem[nxt_vld[0] ? 1 : 0] = in_data;
      nxt_vld = {nxt_vld[0], 1'b1};
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mem_ff <= '{default: '0};
      vld_ff <= 2'h0;
    end
    else
    begin
      mem_ff <= nxt_mem;
      vld_ff <= nxt_vld;
    end
  end

endmodule : sfp_buf

//--- hw/sfp_top.sv
/*
  Pin front end of a small serial flash: select, lanes, pause and
  write-guard handling, with byte streams toward the command core.
  Assumes the core runs on sys_clk_in and steers lane mode and drive.
*/
//
// Functional notes
// - Single lane: sample inbound bits on lane zero at rising clock edges.
// - Single lane: launch outbound bits on lane one at falling edges.
// - Dual and quad lanes turn around; capture rising, launch falling.
// - Dual uses lanes zero and one; quad adds lanes two and three.
// - Select high deselects; every lane floats.
// - Running erase, program or status write survives deselect.
// - Select low starts a transaction; instructions and reads accepted.
// - After power-up, ignore everything until select went high then low.
// - Pause low while selected floats output, ignores input and clock.
// - Pause exists only in single and dual; quad uses it as lane three.
// - Guard low with lock bit one rejects the status write.
// - Status write runs if lock bit zero or guard high.
// - Clock may idle low or high; edges stay the same.
// - One page program carries one to 256 data bytes.
// - Erase picks a 4K sector, 32K block, 64K block or whole array.
`timescale 1ns/100ps
`include "sfp_regs.svh"
module sfp_top (
  input  wire logic                   sys_clk_in,   // Core clock
  input  wire logic                   rst_n_in,     // Async reset
  input  wire logic                   sclk_in,      // Link clock
  input  wire logic                   select_n_in,  // Select, low
  input  wire logic [3:0]             io_lane_in,   // Lane pin levels
  output logic      [3:0]             io_lane_out,  // Lane drive value
  output logic      [3:0]             io_lane_oe_out, // Lane enable
  input  wire sfp_pkg::sfp_mode_e     lane_mode_in, // Lane mode
  input  wire logic                   drive_in,     // Read phase
  output logic      [7:0]             rx_data_out,  // Inbound byte
  output logic                        rx_valid_out, // Inbound valid
  input  wire logic                   rx_ready_in,  // Core ready
  output logic                        rx_overrun_out, // Byte lost
  input  wire logic [7:0]             tx_data_in,   // Outbound byte
  input  wire logic                   tx_valid_in,  // Outbound valid
  output logic                        tx_ready_out, // Slot free
  output logic                        frame_active_out, // Selected
  input  wire logic                   data_phase_in, // Write data
  output logic      [8:0]             page_count_out, // Data bytes
  input  wire logic                   sw_req_in,    // Status write
  input  wire logic                   status_lock_bit_in, // Lock
  output logic                        sw_ok_out,    // Write runs
  output logic                        sw_reject_out, // Write refused
  input  wire logic                   op_start_in,  // Cycle starts
  input  wire logic                   op_done_in,   // Cycle ends
  output logic                        cycle_busy_out, // In progress
  input  wire logic                   erase_req_in, // Erase request
  input  wire sfp_pkg::sfp_erase_e    erase_kind_in, // Granule
  input  wire logic [17:0]            erase_addr_in, // Any address
  output logic      [17:0]            erase_base_out, // Aligned base
  output logic                        erase_valid_out // Base strobe
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  sfp_pkg::sfp_link_ctl_s ctl_d;
  sfp_pkg::sfp_link_ctl_s ctl_q;
  sfp_pkg::sfp_mode_e     mode_eff;
  logic        link_rst_n;
  logic        armed_ff;
  logic        drive_eff;
  logic        paused;
  logic        warm;
  logic [3:0]  step;
  logic [1:0]  warm_ff, nxt_warm;
  logic [7:0]  rx_sh_ff, nxt_rx_sh;
  logic [3:0]  rx_cnt_ff, nxt_rx_cnt;
  logic [7:0]  rx_byte_ff, nxt_rx_byte;
  logic        rx_tgl_ff, nxt_rx_tgl;
  logic [7:0]  tx_sh_ff, nxt_tx_sh;
  logic [3:0]  tx_cnt_ff, nxt_tx_cnt;
  logic [3:0]  nxt_io_out, nxt_io_oe;
  logic        ack_tgl_ff, nxt_ack;
  logic [7:0]  word;
  logic [3:0]  left;
  logic        sel_s, ack_s, rxt_s, guard_pin_s;
  logic        sel_q_ff, rx_seen_ff, req_tgl_ff, ovr_ff, guard_ff;
  logic [7:0]  tx_word_ff, nxt_tx_word;
  logic        nxt_armed, nxt_sel_q, nxt_rx_seen, nxt_req, nxt_ovr;
  logic        nxt_tx_ready, nxt_guard, nxt_sw_ok, nxt_sw_rej;
  logic        nxt_busy, nxt_erase_valid, nxt_frame;
  logic [8:0]  nxt_page;
  logic [17:0] nxt_erase_base;
  logic        frame_start, rx_new, buf_in_ready;

  // Link logic is held in reset while deselected or before arming
  assign link_rst_n = rst_n_in & ~select_n_in & armed_ff;

  // --------------------------------------------------------------------
  // Link side: control crossing and lane decode
  // --------------------------------------------------------------------
  assign ctl_d.mode  = lane_mode_in;
  assign ctl_d.drive = drive_in;
  assign ctl_d.req   = req_tgl_ff;

  // Not reset per frame so the tx handshake survives deselect
  sfp_sync #(.W(4)) u_link_sync (
    .clk_in   (sclk_in),
    .rst_n_in (rst_n_in),
    .d_in     (ctl_d),
    .q_out    (ctl_q)
  );

  // Synced control may be stale for two edges; opcode is single lane
  assign warm      = (warm_ff == `SFP_WARM_EDGES);
  assign mode_eff  = warm ? ctl_q.mode : sfp_pkg::SFP_SINGLE;
  assign drive_eff = warm & ctl_q.drive;
  assign paused    = (mode_eff != sfp_pkg::SFP_QUAD) & ~io_lane_in[3];

  always_comb
  begin
    case (mode_eff)
      sfp_pkg::SFP_QUAD: step = `SFP_STEP_QUAD;
      sfp_pkg::SFP_DUAL: step = `SFP_STEP_DUAL;
      default:           step = `SFP_STEP_SINGLE;
    endcase
  end

  // --------------------------------------------------------------------
  // Link side: capture on rising edges
  // --------------------------------------------------------------------
  always_comb
  begin
    nxt_warm    = warm ? warm_ff : warm_ff + 2'h1;
    nxt_rx_sh   = rx_sh_ff;
    nxt_rx_cnt  = rx_cnt_ff;
    nxt_rx_byte = rx_byte_ff;
    nxt_rx_tgl  = rx_tgl_ff;
    if (!paused && !drive_eff)
    begin
      case (mode_eff)
        sfp_pkg::SFP_QUAD: nxt_rx_sh = {rx_sh_ff[3:0], io_lane_in};
        sfp_pkg::SFP_DUAL: nxt_rx_sh = {rx_sh_ff[5:0], io_lane_in[1:0]};
        default:           nxt_rx_sh = {rx_sh_ff[6:0], io_lane_in[0]};
      endcase
      nxt_rx_cnt = rx_cnt_ff + step;
      if (nxt_rx_cnt == `SFP_BYTE_BITS)
      begin
        nxt_rx_cnt  = 4'h0;
        nxt_rx_byte = nxt_rx_sh;
        nxt_rx_tgl  = ~rx_tgl_ff;
      end
    end
  end

  // Same edges serve both idle polarities of the link clock
  always_ff @(posedge sclk_in or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      warm_ff   <= 2'h0;
      rx_sh_ff  <= 8'h00;
      rx_cnt_ff <= 4'h0;
    end
    else
    begin
      warm_ff   <= nxt_warm;
      rx_sh_ff  <= nxt_rx_sh;
      rx_cnt_ff <= nxt_rx_cnt;
    end
  end

  // Byte and toggle hold across frames for the core to read
  always_ff @(posedge sclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rx_byte_ff <= 8'h00;
      rx_tgl_ff  <= 1'b0;
    end
    else
    begin
      rx_byte_ff <= nxt_rx_byte;
      rx_tgl_ff  <= nxt_rx_tgl;
    end
  end

  // --------------------------------------------------------------------
  // Link side: launch on falling edges
  // --------------------------------------------------------------------
  always_comb
  begin
    nxt_io_out = io_lane_out;
    nxt_io_oe  = `SFP_OE_NONE;
    nxt_tx_sh  = tx_sh_ff;
    nxt_tx_cnt = tx_cnt_ff;
    nxt_ack    = ack_tgl_ff;
    word       = tx_sh_ff;
    left       = tx_cnt_ff;
    if (drive_eff && !paused)
    begin
      if (tx_cnt_ff == 4'h0)
      begin
        left = `SFP_BYTE_BITS;
        // Underrun sends ones rather than stale bits
        word = `SFP_IDLE_BYTE;
        if (ctl_q.req != ack_tgl_ff)
        begin
          word    = tx_word_ff;
          nxt_ack = ~ack_tgl_ff;
        end
      end
      case (mode_eff)
        sfp_pkg::SFP_QUAD:
        begin
          nxt_io_out = word[7:4];
          nxt_io_oe  = `SFP_OE_QUAD;
          nxt_tx_sh  = {word[3:0], 4'h0};
        end
        sfp_pkg::SFP_DUAL:
        begin
          nxt_io_out = {2'h0, word[7:6]};
          nxt_io_oe  = `SFP_OE_DUAL;
          nxt_tx_sh  = {word[5:0], 2'h0};
        end
        default:
        begin
          nxt_io_out = {2'h0, word[7], 1'b0};
          nxt_io_oe  = `SFP_OE_SINGLE;
          nxt_tx_sh  = {word[6:0], 1'b0};
        end
      endcase
      nxt_tx_cnt = left - step;
    end
  end

  always_ff @(negedge sclk_in or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      io_lane_out    <= 4'h0;
      io_lane_oe_out <= `SFP_OE_NONE;
      tx_sh_ff       <= 8'h00;
      tx_cnt_ff      <= 4'h0;
    end
    else
    begin
      io_lane_out    <= nxt_io_out;
      io_lane_oe_out <= nxt_io_oe;
      tx_sh_ff       <= nxt_tx_sh;
      tx_cnt_ff      <= nxt_tx_cnt;
    end
  end

  always_ff @(negedge sclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      ack_tgl_ff <= 1'b0;
    else
      ack_tgl_ff <= nxt_ack;
  end

  // --------------------------------------------------------------------
  // Core side: crossings, streams and pin-derived status
  // --------------------------------------------------------------------
  sfp_sync #(.W(4)) u_sys_sync (
    .clk_in   (sys_clk_in),
    .rst_n_in (rst_n_in),
    .d_in     ({select_n_in, ack_tgl_ff, rx_tgl_ff, io_lane_in[2]}),
    .q_out    ({sel_s, ack_s, rxt_s, guard_pin_s})
  );

  // Link byte stays put for at least two link edges after its toggle
  sfp_buf #(.W(8)) u_rx_buf (
    .clk_in    (sys_clk_in),
    .rst_n_in  (rst_n_in),
    .in_data   (rx_byte_ff),
    .in_valid  (rx_new),
    .in_ready  (buf_in_ready),
    .out_data  (rx_data_out),
    .out_valid (rx_valid_out),
    .out_ready (rx_ready_in)
  );

  always_comb
  begin
    frame_start     = sel_q_ff & ~sel_s;
    rx_new          = rxt_s ^ rx_seen_ff;
    nxt_armed       = armed_ff | sel_s;
    nxt_sel_q       = sel_s;
    nxt_rx_seen     = rxt_s;
    nxt_frame       = ~sel_s;
    // Set wins over clear at a frame start
    nxt_ovr         = (ovr_ff & ~frame_start) | (rx_new & ~buf_in_ready);
    nxt_tx_word     = tx_word_ff;
    nxt_req         = req_tgl_ff;
    nxt_tx_ready    = tx_ready_out;
    if (tx_ready_out && tx_valid_in)
    begin
      nxt_tx_word  = tx_data_in;
      nxt_req      = ~req_tgl_ff;
      nxt_tx_ready = 1'b0;
    end
    else if (!tx_ready_out && (req_tgl_ff == ack_s))
      nxt_tx_ready = 1'b1;
    nxt_page = page_count_out;
    if (frame_start)
      nxt_page = 9'h000;
    else if (rx_new && buf_in_ready && data_phase_in &&
             page_count_out != `SFP_PAGE_BYTES)
      nxt_page = page_count_out + 9'h001;
    // In quad the pin is a data lane, so the last guard level holds
    nxt_guard = (lane_mode_in == sfp_pkg::SFP_QUAD) ? guard_ff
                                                    : guard_pin_s;
    nxt_sw_rej = sw_req_in & ~guard_ff &
                 (status_lock_bit_in == `SFP_LOCK_SET);
    nxt_sw_ok  = sw_req_in & ~nxt_sw_rej;
    // Deselect has no say over a running cycle
    nxt_busy = (cycle_busy_out & ~op_done_in) | op_start_in;
    nxt_erase_valid = erase_req_in;
    nxt_erase_base  = erase_base_out;
    if (erase_req_in)
    begin
      case (erase_kind_in)
        sfp_pkg::SFP_SECTOR: nxt_erase_base = erase_addr_in & `SFP_SECTOR_MASK;
        sfp_pkg::SFP_BLK32:  nxt_erase_base = erase_addr_in & `SFP_BLK32_MASK;
        sfp_pkg::SFP_BLK64:  nxt_erase_base = erase_addr_in & `SFP_BLK64_MASK;
        default:             nxt_erase_base = `SFP_CHIP_BASE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      armed_ff         <= 1'b0;
      sel_q_ff         <= 1'b0;
      rx_seen_ff       <= 1'b0;
      frame_active_out <= 1'b0;
      ovr_ff           <= 1'b0;
      tx_word_ff       <= 8'h00;
      req_tgl_ff       <= 1'b0;
      tx_ready_out     <= 1'b0;
      page_count_out   <= 9'h000;
      guard_ff         <= 1'b0;
      sw_reject_out    <= 1'b0;
      sw_ok_out        <= 1'b0;
      cycle_busy_out   <= 1'b0;
      erase_valid_out  <= 1'b0;
      erase_base_out   <= 18'h0_0000;
    end
    else
    begin
      armed_ff         <= nxt_armed;
      sel_q_ff         <= nxt_sel_q;
      rx_seen_ff       <= nxt_rx_seen;
      frame_active_out <= nxt_frame;
      ovr_ff           <= nxt_ovr;
      tx_word_ff       <= nxt_tx_word;
      req_tgl_ff       <= nxt_req;
      tx_ready_out     <= nxt_tx_ready;
      page_count_out   <= nxt_page;
      guard_ff         <= nxt_guard;
      sw_reject_out    <= nxt_sw_rej;
      sw_ok_out        <= nxt_sw_ok;
      cycle_busy_out   <= nxt_busy;
      erase_valid_out  <= nxt_erase_valid;
      erase_base_out   <= nxt_erase_base;
    end
  end

  assign rx_overrun_out = ovr_ff;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  deselect_float_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    select_n_in |-> io_lane_oe_out == `SFP_OE_NONE)
    else $error("lanes driven while deselected");

  unarmed_quiet_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    !armed_ff |-> io_lane_oe_out == `SFP_OE_NONE && !rx_valid_out)
    else $error("activity before first select edge");

  single_capture_a: assert property (
    @(posedge sclk_in) disable iff (!link_rst_n)
    (rx_cnt_ff == 4'h7 && mode_eff == sfp_pkg::SFP_SINGLE &&
     !paused && !drive_eff)
    |=> rx_tgl_ff != $past(rx_tgl_ff) &&
        rx_byte_ff[0] == $past(io_lane_in[0]))
    else $error("single lane byte not captured");

  single_launch_a: assert property (
    @(posedge sclk_in) disable iff (!link_rst_n)
    (io_lane_oe_out != `SFP_OE_NONE && mode_eff == sfp_pkg::SFP_SINGLE)
    |-> io_lane_oe_out == `SFP_OE_SINGLE)
    else $error("single lane drives wrong pins");

  pause_float_a: assert property (
    @(posedge sclk_in) disable iff (!link_rst_n)
    paused ##1 paused |-> io_lane_oe_out == `SFP_OE_NONE)
    else $error("output driven while paused");

  pause_keep_a: assert property (
    @(posedge sclk_in) disable iff (!link_rst_n)
    paused |=> $stable(rx_sh_ff) && $stable(rx_cnt_ff))
    else $error("shift state moved while paused");

  quad_no_pause_a: assert property (
    @(posedge sclk_in) disable iff (!link_rst_n)
    (mode_eff == sfp_pkg::SFP_QUAD && drive_eff)
    |-> io_lane_oe_out == `SFP_OE_QUAD)
    else $error("quad launch stalled by lane three");

  guard_reject_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (sw_req_in && !guard_ff && status_lock_bit_in)
    |=> sw_reject_out && !sw_ok_out)
    else $error("locked status write not refused");

  guard_allow_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (sw_req_in && (guard_ff || !status_lock_bit_in)) |=> sw_ok_out)
    else $error("allowed status write refused");

  busy_survive_a: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (cycle_busy_out && !op_done_in) |=> cycle_busy_out)
    else $error("running cycle dropped");

endmodule : sfp_top

//--- tb/sfp_host.sv
/*
  Host model of the link: drives clock, select and inbound lanes.
  Assumes single-lane writes and reads on one, two or four lanes;
  lane levels are resolved here.
*/
`timescale 1ns/100ps
module sfp_host (
  input  wire logic [3:0] dev_val_in, // Device drive value
  input  wire logic [3:0] dev_oe_in,  // Device enable
  output logic      [3:0] pin_out,    // Lane levels
  output logic            sclk_out,   // Link clock
  output logic            sel_n_out   // Select, low
);
  logic [3:0] host_val; // Lane0 data, lane2 guard, lane3 pause
  logic       idle_hi;  // Clock idle level

  // Released output lane shows the inverse, never a stale copy
  always_comb
    for (int i = 0; i < 4; i++)
      pin_out[i] = dev_oe_in[i] ? dev_val_in[i] :
                   (i == 1) ? ~dev_val_in[i] : host_val[i];

  initial
  begin
    host_val  = 4'b1101;
    idle_hi   = 1'b0;
    sclk_out  = 1'b0;
    sel_n_out = 1'b1;
  end

  task automatic begin_frame();
    sclk_out = idle_hi;
    #200 sel_n_out = 1'b0;
    #32;
  endtask : begin_frame

  task automatic end_frame();
    #32 sclk_out = idle_hi;
    #32 sel_n_out = 1'b1;
    #200;
  endtask : end_frame

  // Data moves with the low phase; a pause mid-byte wiggles the clock
  task automatic send_byte(input logic [7:0] b, input logic hold);
    for (int i = 7; i >= 0; i--)
    begin
      sclk_out = 1'b0;
      host_val[0] = b[i];
      if (hold && i == 3)
      begin
        #16 host_val[3] = 1'b0;
        host_val[0] = ~b[i];
        #32 sclk_out = 1'b1;
        #32 sclk_out = 1'b0;
        #32 host_val[3] = 1'b1;
        host_val[0] = b[i];
      end
      #32 sclk_out = 1'b1;
      #32;
    end
  endtask : send_byte

  // Two warm-up clocks, then one byte over w lanes sampled on rises
  task automatic read_byte(input int w, output logic [7:0] got);
    got = 8'h00;
    for (int i = 0; i < 2 + 8 / w; i++)
    begin
      sclk_out = 1'b0;
      #32;
      if (i >= 2)
        got = (w == 4) ? {got[3:0], pin_out} :
              (w == 2) ? {got[5:0], pin_out[1:0]} :
                         {got[6:0], pin_out[1]};
      sclk_out = 1'b1;
      #32;
    end
  endtask : read_byte
endmodule : sfp_host

//--- tb/serial_flash_pin_interface_test.sv
/*
  Self-checking bench of sfp_top against a queue model.
  Assumes sfp_host as link partner; core ports driven here.
*/
`timescale 1ns/100ps
module serial_flash_pin_interface_test;
  logic sys_clk, rst_n, sclk, sel_n, drive, rx_ready, tx_valid;
  logic [3:0] pin, lval, loe;
  logic [7:0] rx_data, tx_data, b;
  logic rx_valid, rx_ovr, tx_ready, fr_act, dphase, sw_req, lock;
  logic sw_ok, sw_rej, op_start, op_done, busy, er_req, er_valid;
  logic [8:0] pcount;
  logic [17:0] er_addr, er_base, exp;
  logic [31:0] seed;
  sfp_pkg::sfp_mode_e mode;
  sfp_pkg::sfp_erase_e er_kind;
  logic [7:0] rx_q[$];
  int err_total, compares;

  sfp_host i_sfp_host (.dev_val_in(lval), .dev_oe_in(loe), .pin_out(pin),
    .sclk_out(sclk), .sel_n_out(sel_n));

  sfp_top i_sfp_top (.sys_clk_in(sys_clk), .rst_n_in(rst_n),
    .sclk_in(sclk), .select_n_in(sel_n), .io_lane_in(pin),
    .io_lane_out(lval), .io_lane_oe_out(loe), .lane_mode_in(mode),
    .drive_in(drive), .rx_data_out(rx_data), .rx_valid_out(rx_valid),
    .rx_ready_in(rx_ready), .rx_overrun_out(rx_ovr),
    .tx_data_in(tx_data), .tx_valid_in(tx_valid),
    .tx_ready_out(tx_ready), .frame_active_out(fr_act),
    .data_phase_in(dphase), .page_count_out(pcount),
    .sw_req_in(sw_req), .status_lock_bit_in(lock), .sw_ok_out(sw_ok),
    .sw_reject_out(sw_rej), .op_start_in(op_start),
    .op_done_in(op_done), .cycle_busy_out(busy), .erase_req_in(er_req),
    .erase_kind_in(er_kind), .erase_addr_in(er_addr),
    .erase_base_out(er_base), .erase_valid_out(er_valid));

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic chk(input string what, input logic [17:0] e,
                     input logic [17:0] g);
    compares++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", what, e, g);
    end
  endtask : chk

  task automatic final_report();
    if (err_total == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  // Every delivered byte is matched against the model queue
  always @(posedge sys_clk)
    if (rx_valid === 1'b1 && rx_ready === 1'b1)
    begin
      if (rx_q.size() == 0)
        chk("rx_extra", 18'h0_0000, 18'h0_0001);
      else
        chk("rx_data", {10'h0, rx_q.pop_front()}, {10'h0, rx_data});
    end

  initial
  begin
    {rst_n, drive, rx_ready, tx_valid, dphase, sw_req, lock} = '0;
    {op_start, op_done, er_req} = '0;
    {tx_data, er_addr} = '0;
    mode = sfp_pkg::SFP_SINGLE;
    er_kind = sfp_pkg::SFP_SECTOR;
    seed = 32'h0000_6f94;
    tick(10);
    rst_n = 1'b1;
    tick(2);
    chk("oe_idle", 18'h0_0000, {14'h0, loe});
    // Both clock idle levels; receiver stalls until two bytes wait
    for (int m = 0; m < 2; m++)
    begin
      i_sfp_host.idle_hi = m[0];
      dphase = 1'b1;
      i_sfp_host.begin_frame();
      for (int k = 0; k < 2; k++)
      begin
        seed = xs(seed);
        b = seed[7:0];
        rx_q.push_back(b);
        i_sfp_host.send_byte(b, k == 1);
      end
      tick(12);
      chk("overrun", 18'h0_0000, {17'h0, rx_ovr});
      rx_ready = 1'b1;
      for (int t = 0; t < 300 && rx_q.size() != 0; t++)
        tick(1);
      if (rx_q.size() != 0)
      begin
        chk("rx_timeout", 18'h0_0000, 18'h0_0001);
        final_report();
      end
      chk("active", 18'h0_0001, {17'h0, fr_act});
      chk("page_count", 18'h0_0002, {9'h0, pcount});
      chk("oe_single", 18'h0_0000, {14'h0, loe & 4'b1101});
      i_sfp_host.end_frame();
      rx_ready = 1'b0;
      chk("oe_desel", 18'h0_0000, {14'h0, loe});
    end
    // Reads on one, two and four lanes; quad ignores a low pause pin
    for (int w = 1; w <= 4; w *= 2)
    begin
      seed = xs(seed);
      tx_data = seed[7:0];
      chk("tx_ready", 18'h0_0001, {17'h0, tx_ready});
      tx_valid = 1'b1;
      tick(1);
      tx_valid = 1'b0;
      mode = (w == 4) ? sfp_pkg::SFP_QUAD :
             (w == 2) ? sfp_pkg::SFP_DUAL : sfp_pkg::SFP_SINGLE;
      drive = 1'b1;
      i_sfp_host.host_val[3] = (w != 4);
      i_sfp_host.begin_frame();
      i_sfp_host.read_byte(w, b);
      chk("tx_data", {10'h0, tx_data}, {10'h0, b});
      i_sfp_host.end_frame();
      i_sfp_host.host_val[3] = 1'b1;
      chk("oe_read", 18'h0_0000, {14'h0, loe});
      chk("tx_back", 18'h0_0001, {17'h0, tx_ready});
    end
    drive = 1'b0;
    mode = sfp_pkg::SFP_SINGLE;
    // Guard pin against lock bit, all four pairs
    for (int c = 0; c < 4; c++)
    begin
      i_sfp_host.host_val[2] = c[1];
      lock = c[0];
      tick(6);
      sw_req = 1'b1;
      tick(1);
      sw_req = 1'b0;
      chk("sw_rej", {17'h0, ~c[1] & c[0]}, {17'h0, sw_rej});
      chk("sw_ok", {17'h0, c[1] | ~c[0]}, {17'h0, sw_ok});
    end
    // Erase granules on random addresses
    for (int e = 0; e < 4; e++)
    begin
      seed = xs(seed);
      er_addr = seed[17:0];
      er_kind = sfp_pkg::sfp_erase_e'(e);
      exp = (e == 0) ? er_addr & 18'h3_F000 : (e == 1) ? er_addr & 18'h3_8000
          : (e == 2) ? er_addr & 18'h3_0000 : 18'h0_0000;
      er_req = 1'b1;
      tick(1);
      er_req = 1'b0;
      chk("er_valid", 18'h0_0001, {17'h0, er_valid});
      chk("er_base", exp, er_base);
    end
    // Cycle in progress survives a whole frame
    op_start = 1'b1;
    tick(1);
    op_start = 1'b0;
    i_sfp_host.begin_frame();
    i_sfp_host.end_frame();
    chk("busy_hold", 18'h0_0001, {17'h0, busy});
    op_done = 1'b1;
    tick(2);
    op_done = 1'b0;
    chk("busy_clear", 18'h0_0000, {17'h0, busy});
    final_report();
  end
endmodule : serial_flash_pin_interface_test
